// ---- adc_trigger_result_amp_sync_tb.sv ----
// bench for the converter control block
// assumes the trigger source model atrc_src
`timescale 1ns/1ns
`default_nettype none
module adc_trigger_result_amp_sync_tb;
  import atrc_pkg::*;
  localparam int P = 4;
  logic        clk, rst_n, wr, rd, vec_ack, amp_chg, busy, fire;
  logic [3:0]  fire_code;
  logic [7:0]  addr, wdata, rdata;
  logic [9:0]  code;
  logic [10:0] pin_in, pin_rd;
  logic [12:0] flags;
  int          err_count, cmp_count;

  always #5 clk = ~clk;

  atrc_ctrl #(.PRESC(P)) u_dut (
    .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .trig_flag(flags), .amp_event(7'h00), .vec_ack,
    .conv_code(code), .amp_out_change(amp_chg), .busy,
    .amp_phase_clk(), .pin_in, .pin_read(pin_rd));
  atrc_src u_src (.clk, .rst_n, .fire, .fire_code,
    .trig_flag(flags));

  function automatic logic [15:0] lay(input logic [9:0] r,
                                      input logic l);
    return l ? {r, 6'h00} : {6'h00, r};
  endfunction
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= {4'h0, a};
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= {4'h0, a};
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic fire_ev(input logic [3:0] c);
    @(posedge clk);
    fire      <= 1'b1;
    fire_code <= c;
    @(posedge clk);
    fire      <= 1'b0;
  endtask
  // counts busy cycles, stops once busy has fallen again
  task automatic watch(input int lim, output int n);
    n = 0;
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      if (busy === 1'b1) n++;
      else if (n > 0) break;
    end
    if (busy !== 1'b0) begin
      err_count++;
      give_verdict();
    end
  endtask

  initial begin
    logic [7:0]  d, lo, hi;
    logic [9:0]  r0;
    logic [15:0] e;
    logic [3:0]  ofs [4];
    int          n, n0;
    {clk, rst_n, wr, rd, vec_ack, amp_chg, fire} = '0;
    {fire_code, addr, wdata, code, pin_in} = '0;
    err_count = 0;
    cmp_count = 0;
    ofs = '{OFF_RES_LO, OFF_RES_HI, OFF_DIS0, 4'hf};
    void'($urandom(32'ha336));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) begin
      rd_reg(ofs[i], d);
      chk("reset_val", d, 8'h00);
    end
    for (int k = 0; k < 4; k++) begin
      r0 = 10'($urandom);
      code <= r0;
      wr_reg(OFF_CHSEL, 8'h00);
      wr_reg(OFF_CTRL_A, 8'hc0);
      watch(200, n);
      rd_reg(OFF_CTRL_A, d);
      chk("status", d[7:4], 4'h9);
      rd_reg(OFF_RES_LO, lo);
      rd_reg(OFF_RES_HI, hi);
      chk("right_adj", {hi, lo}, lay(r0, 1'b0));
      wr_reg(OFF_CHSEL, 8'h20);
      rd_reg(OFF_RES_LO, lo);
      rd_reg(OFF_RES_HI, hi);
      chk("left_adj", {hi, lo}, lay(r0, 1'b1));
      if (k[0]) wr_reg(OFF_CTRL_A, 8'h90);
      else begin
        @(posedge clk) vec_ack <= 1'b1;
        @(posedge clk) vec_ack <= 1'b0;
      end
      rd_reg(OFF_CTRL_A, d);
      chk("done_clr", d[4], 1'b0);
    end
    e = lay(r0, 1'b1);
    rd_reg(OFF_RES_LO, lo);
    code <= ~r0;
    wr_reg(OFF_CTRL_A, 8'hc0);
    watch(200, n);
    rd_reg(OFF_RES_HI, hi);
    chk("locked_hi", hi, e[15:8]);
    wr_reg(OFF_CTRL_A, 8'hd0);
    watch(200, n);
    rd_reg(OFF_RES_HI, hi);
    e = lay(~r0, 1'b1);
    chk("high_only", hi, e[15:8]);
    wr_reg(OFF_CHSEL, 8'(CH_AMP0));
    wr_reg(OFF_AMP0, 8'h00);
    wr_reg(OFF_AMP0, 8'h80);
    for (int k = 0; k < 3; k++) begin
      wr_reg(OFF_CTRL_A, 8'hd0);
      fork
        watch(300, n);
        begin
          @(posedge clk) amp_chg <= (k == 2);
          repeat (20) @(posedge clk);
          amp_chg <= 1'b0;
        end
      join
      if (k < 2) chk("amp_lat", n >= 13 * P && n <= 15 * P + 2,
                     1'b1);
      else chk("restart", n > n0 && n > 15 * P + 2, 1'b1);
      n0 = n;
    end
    wr_reg(OFF_CHSEL, 8'h00);
    wr_reg(OFF_CTRL_B, 8'h01);
    wr_reg(OFF_CTRL_A, 8'h90);
    fire_ev(4'h1);
    watch(40, n);
    chk("single_mode", n, 0);
    for (int c = 1; c < 16; c++) begin
      wr_reg(OFF_CTRL_B, 8'(c));
      wr_reg(OFF_CTRL_A, 8'hb0);
      fire_ev(4'(c));
      watch(200, n);
      chk("auto_start", n > 0, c < 14);
      watch(60, n);
      chk("one_start", n, 0);
    end
    wr_reg(OFF_CTRL_B, 8'h00);
    wr_reg(OFF_CTRL_A, 8'hf0);
    repeat (300) @(posedge clk);
    rd_reg(OFF_CTRL_A, d);
    n = 0;
    repeat (60) begin
      @(posedge clk);
      #1 n += busy;
    end
    chk("free_run", {d[4], n > 50}, 2'b11);
    wr_reg(OFF_CTRL_A, 8'h90);
    watch(200, n);
    repeat (3) begin
      d = 8'($urandom);
      wr_reg(OFF_DIS0, d);
      wr_reg(OFF_DIS1, 8'h00);
      pin_in <= 11'($urandom);
      repeat (5) @(posedge clk);
      #1 chk("pins", pin_rd[7:0], pin_in[7:0] & ~d);
      rd_reg(OFF_DIS0, lo);
      chk("dis0_rw", lo, d);
    end
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- atrc_ctrl.sv ----
// converter control: triggers, result lock, input disable, amplifier sync
// assumes synchronous event sources and an analog core giving a 10-bit code
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RL1: trigger select ignored unless auto mode
// RL2: start on rising edge of selected flag
// RL3: power-stage event starts if previous done
// RL4: four-bit trigger code decode table
// RL5: completion writes high and low result
// RL6: low read locks result until high read
// RL7: software reads low byte before high
// RL8: right or left adjusted result layout
// RL9: left adjust allows high byte only
// RL10: disable bit forces port input zero
// RL11: software disables unused analog inputs
// RL12: three amplified channels, four gains
// RL13: amplifier clocked by event or div8
// RL14: div8 sync aligns sample phase
// RL15: phase low start takes 13 cycles
// RL16: phase high start takes 14 cycles
// RL17: select sync source, then enable amplifier
// RL18: software selects amplified channel then start
// RL19: no other channel while amplified busy
// RL20: amplifier change while sampling restarts conversion
// RL21: power-stage trigger below quarter converter clock
// RL22: auto enable selects auto mode
// RL23: start bit self-clears, zero write ignored
// RL24: done flag set on update, cleared
// RL25: left adjust change shows immediately
// RL26: reserved trigger codes never start
// RL27: one start per detected rising edge
module atrc_ctrl
  import atrc_pkg::*;
#(
  parameter int PRESC = PRESC_DEFAULT
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [7:0]       rdata,
  // trigger flags, index is trigger code minus one
  input  wire logic [12:0] trig_flag,
  // amplifier sync events per source code 1..7, unused; sync takes trig_flag
  input  wire logic [6:0]  amp_event,
  // vector execution acknowledge
  input  wire logic        vec_ack,
  // analog core
  input  wire logic [9:0]  conv_code,
  input  wire logic        amp_out_change,
  output logic             busy,
  output logic             amp_phase_clk,
  // digital pins
  input  wire logic [10:0] pin_in,
  output logic [10:0]      pin_read
);
  initial begin
    if (PRESC < 1 || PRESC > 255) $error("PRESC out of range");
  end

  atrc_regs_t r_r;
  atrc_regs_t r_nxt;

  function automatic logic [7:0] amp_reg(input atrc_regs_t s,
                                         input logic [1:0] i);
    amp_reg = (i == 2'd0) ? s.amp0 : (i == 2'd1) ? s.amp1 : s.amp2;
  endfunction

  logic        tick;
  logic        div_tick;
  logic [13:0] ev_now;
  logic        trig;
  logic        is_amp;
  logic [1:0]  amp_idx;
  logic [7:0]  amp_cfg;
  logic        amp_sync_ev;
  logic [7:0]  res_hi;
  logic [7:0]  res_lo;
  logic        done_ev;

  assign tick     = (r_r.presc == 8'(PRESC - 1));
  assign div_tick = tick && (r_r.phase == 3'(AMP_DIV - 1));
  // flag index 13 is tied to zero; amp_event is not folded in
  assign ev_now   = {1'b0, trig_flag};
  assign is_amp   = (r_r.chsel[4:0] >= CH_AMP0) && (r_r.chsel[4:0] <= CH_AMP2);
  assign amp_idx  = 2'(r_r.chsel[4:0] - CH_AMP0);
  assign amp_cfg  = amp_reg(r_r, amp_idx);

  // sync clock from divided converter clock or selected event [RL13]
  always_comb begin
    if (amp_cfg[2:0] == 3'd0) begin
      amp_sync_ev = div_tick;
    end else begin
      amp_sync_ev = r_r.ev_s2[4'(amp_cfg[2:0]) - 4'd1] ? 1'b1 : 1'b0;
    end
  end

  // result layout follows live left adjust bit [RL8] [RL25]
  always_comb begin
    if (r_r.chsel[BIT_LEFT_ADJ]) begin
      res_hi = r_r.result[9:2];
      res_lo = {r_r.result[1:0], 6'h00};
    end else begin
      res_hi = {6'h00, r_r.result[9:8]};
      res_lo = r_r.result[7:0];
    end
  end

  // trigger selection and edge detection
  always_comb begin
    logic [3:0] c;
    c = r_r.trg_sel;
    trig = 1'b0;
    if (r_r.ctrl_a[BIT_AUTO] && c == TRG_FREE) begin
      // free running: each completion starts the next one
      trig = done_ev;                                               // [RL4]
    end else if (r_r.ctrl_a[BIT_AUTO] && c <= TRG_LAST) begin // [RL1] [RL22] [RL26]
      if (c >= TRG_PS_LO && c <= TRG_PS_HI) begin
        trig = r_r.ev_s2[c - 4'd1] && !r_r.busy;                   // [RL3]
      end else begin
        trig = r_r.ev_s2[c - 4'd1] && !r_r.flag_q[c - 4'd1];       // [RL2] [RL27]
      end
    end
  end

  // first tick opens the conversion, the thirteenth after it ends it
  assign done_ev = (r_r.st == ST_CONV) && tick && (r_r.cnt == 5'd0);

  always_comb begin
    r_nxt = r_r;
    r_nxt.ev_s1   = ev_now;
    r_nxt.ev_s2   = r_r.ev_s1;
    r_nxt.flag_q  = r_r.ev_s2;
    r_nxt.amp_o_s1 = amp_out_change;
    r_nxt.amp_o_s2 = r_r.amp_o_s1;
    r_nxt.amp_o_q  = r_r.amp_o_s2;
    r_nxt.pin_s1  = pin_in;
    r_nxt.pin_s2  = r_r.pin_s1;
    r_nxt.pin_q   = r_r.pin_s2 & ~{r_r.dis1[2:0], r_r.dis0};       // [RL10]
    r_nxt.presc   = tick ? 8'h00 : r_r.presc + 8'h01;
    if (tick) r_nxt.phase = r_r.phase + 3'd1;
    if (div_tick) r_nxt.ck_out = ~r_r.ck_out;
    r_nxt.rdata = 8'h00;

    if (wr) begin
      unique case (addr[3:0])
        OFF_CTRL_A: begin
          r_nxt.ctrl_a[7] = wdata[7];
          r_nxt.ctrl_a[5] = wdata[5];
          r_nxt.ctrl_a[3:0] = wdata[3:0];
          if (wdata[BIT_START]) r_nxt.ctrl_a[BIT_START] = 1'b1;     // [RL23]
          if (wdata[BIT_DONE]) r_nxt.ctrl_a[BIT_DONE] = 1'b0;       // [RL24]
        end
        OFF_CTRL_B: r_nxt.trg_sel = wdata[3:0];                     // [RL4]
        OFF_CHSEL:  r_nxt.chsel = {wdata[7:5], wdata[4:0]};
        OFF_DIS0:   r_nxt.dis0 = wdata;
        OFF_DIS1:   r_nxt.dis1 = wdata[6:0];
        OFF_AMP0:   r_nxt.amp0 = wdata;                             // [RL12]
        OFF_AMP1:   r_nxt.amp1 = wdata;
        OFF_AMP2:   r_nxt.amp2 = wdata;
        default: ;
      endcase
    end
    if (vec_ack) r_nxt.ctrl_a[BIT_DONE] = 1'b0;                     // [RL24]

    if (rd) begin
      unique case (addr[3:0])
        OFF_CTRL_A: r_nxt.rdata = r_r.ctrl_a;
        OFF_CTRL_B: r_nxt.rdata = {4'h0, r_r.trg_sel};
        OFF_CHSEL:  r_nxt.rdata = r_r.chsel;
        OFF_RES_LO: begin
          r_nxt.rdata = res_lo;
          r_nxt.lock = 1'b1;                                        // [RL6]
        end
        OFF_RES_HI: begin
          r_nxt.rdata = res_hi;
          r_nxt.lock = 1'b0;                                        // [RL6]
        end
        OFF_DIS0:   r_nxt.rdata = r_r.dis0;
        OFF_DIS1:   r_nxt.rdata = {1'b0, r_r.dis1};
        OFF_AMP0:   r_nxt.rdata = r_r.amp0;
        OFF_AMP1:   r_nxt.rdata = r_r.amp1;
        OFF_AMP2:   r_nxt.rdata = r_r.amp2;
        default:    r_nxt.rdata = 8'h00;
      endcase
    end

    unique case (r_r.st)
      ST_IDLE: begin
        if (r_r.ctrl_a[BIT_START] && r_r.ctrl_a[BIT_ENABLE]) begin
          r_nxt.busy = 1'b1;
          r_nxt.amp_conv = is_amp && amp_cfg[BIT_AMP_EN];
          r_nxt.cnt = 5'(CONV_CYCLES);
          // phase high costs one extra cycle [RL14] [RL16]
          if (is_amp && amp_cfg[BIT_AMP_EN] && r_r.ck_out) begin
            r_nxt.st = ST_SYNC;
          end else begin
            r_nxt.st = ST_CONV;                                     // [RL15]
          end
        end
      end
      ST_SYNC: begin
        if (tick) r_nxt.st = ST_CONV;
      end
      ST_CONV: begin
        // channel select not held; writes take effect while busy [RL19]
        if (r_r.amp_conv && r_r.amp_o_q &&
            r_r.cnt > 5'(CONV_CYCLES - SAMPLE_CYCLES)) begin
          r_nxt.cnt = 5'(CONV_CYCLES);                              // [RL20]
        end else if (tick) begin
          r_nxt.cnt = r_r.cnt - 5'd1;
        end
        if (done_ev) begin
          r_nxt.st = ST_IDLE;
          r_nxt.busy = 1'b0;
          r_nxt.ctrl_a[BIT_START] = 1'b0;                           // [RL23]
          r_nxt.ctrl_a[BIT_DONE] = 1'b1;                            // [RL24]
          if (!r_r.lock) r_nxt.result = conv_code;                  // [RL5] [RL6]
        end
      end
      default: r_nxt.st = ST_IDLE;
    endcase
    // a trigger in the completion cycle wins over the self-clear
    if (trig && r_r.ctrl_a[BIT_ENABLE]) begin
      r_nxt.ctrl_a[BIT_START] = 1'b1;
    end
    // amplification runs on every sync event while enabled [RL17]
    if (amp_sync_ev && amp_cfg[BIT_AMP_EN] && amp_cfg[2:0] != 3'd0) begin
      r_nxt.ck_out = ~r_r.ck_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign rdata         = r_r.rdata;
  assign busy          = r_r.busy;
  assign amp_phase_clk = r_r.ck_out;
  assign pin_read      = r_r.pin_q;

  sync_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (r_r.st == ST_IDLE && r_nxt.st == ST_SYNC) |-> r_r.ck_out)
    else $error("sync wait without phase high"); // [RL16]
  start_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    done_ev && !trig |=> !r_r.ctrl_a[BIT_START])
    else $error("start bit not cleared"); // [RL23]
  done_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    done_ev && !vec_ack |=> r_r.ctrl_a[BIT_DONE])
    else $error("done flag not set"); // [RL24]
  lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    r_r.lock |=> $stable(r_r.result))
    else $error("result changed while locked"); // [RL6]
  pin_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    r_r.dis0[0] && $past(r_r.dis0[0]) |-> !pin_read[0])
    else $error("disabled pin reads one"); // [RL10]
  single_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    !r_r.ctrl_a[BIT_AUTO] |-> !trig)
    else $error("trigger in single mode"); // [RL1]
  reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    r_r.trg_sel > TRG_LAST |-> !trig)
    else $error("reserved code triggered"); // [RL26]
  layout_a: assert property (@(posedge clk) disable iff (!rst_n)
    !r_r.chsel[BIT_LEFT_ADJ] |-> res_hi[7:2] == 6'h00)
    else $error("right adjust high bits set"); // [RL8]
endmodule
`default_nettype wire

// ---- atrc_pkg.sv ----
// package for the converter trigger, result and amplifier sync control block
// assumes a single system clock domain
package atrc_pkg;
  // register offsets, plain byte port
  localparam logic [3:0] OFF_CTRL_A  = 4'h0;
  localparam logic [3:0] OFF_CTRL_B  = 4'h1;
  localparam logic [3:0] OFF_CHSEL   = 4'h2;
  localparam logic [3:0] OFF_RES_LO  = 4'h3;
  localparam logic [3:0] OFF_RES_HI  = 4'h4;
  localparam logic [3:0] OFF_DIS0    = 4'h5;
  localparam logic [3:0] OFF_DIS1    = 4'h6;
  localparam logic [3:0] OFF_AMP0    = 4'h7;
  localparam logic [3:0] OFF_AMP1    = 4'h8;
  localparam logic [3:0] OFF_AMP2    = 4'h9;
  // control a, channel select and amplifier field positions
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_START    = 6;
  localparam int BIT_AUTO     = 5;
  localparam int BIT_DONE     = 4;
  localparam int BIT_LEFT_ADJ = 5;
  localparam int BIT_AMP_EN   = 7;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // trigger source codes
  localparam logic [3:0] TRG_FREE    = 4'h0;
  localparam logic [3:0] TRG_PS_LO   = 4'h7;
  localparam logic [3:0] TRG_PS_HI   = 4'h9;
  localparam logic [3:0] TRG_LAST    = 4'hd;
  // channel codes of the amplified inputs
  localparam logic [4:0] CH_AMP0     = 5'h0e;
  localparam logic [4:0] CH_AMP2     = 5'h10;
  // timing in converter clock cycles, prescaler default in system clocks
  localparam int CONV_CYCLES   = 13;
  localparam int SYNC_CYCLES   = 1;
  localparam int AMP_DIV       = 8;
  localparam int SAMPLE_CYCLES = 2;
  localparam int PRESC_DEFAULT = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_CONV} atrc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } atrc_bus_t;

  typedef struct packed {
    atrc_state_t st;
    logic [7:0]  ctrl_a;
    logic [3:0]  trg_sel;
    logic [7:0]  chsel;
    logic [7:0]  dis0;
    logic [6:0]  dis1;
    logic [7:0]  amp0;
    logic [7:0]  amp1;
    logic [7:0]  amp2;
    logic [9:0]  result;
    logic        lock;
    logic [7:0]  presc;
    logic [2:0]  phase;
    logic [4:0]  cnt;
    logic        amp_conv;
    logic [13:0] flag_q;
    logic [13:0] ev_s1;
    logic [13:0] ev_s2;
    logic        amp_o_s1;
    logic        amp_o_s2;
    logic        amp_o_q;
    logic [7:0]  rdata;
    logic [7:0]  pin_out;
    logic [10:0] pin_s1;
    logic [10:0] pin_s2;
    logic [10:0] pin_q;
    logic        busy;
    logic        ck_out;
  } atrc_regs_t;
endpackage

// ---- atrc_src.sv ----
// trigger source model: timer, comparator, power stage flags
// assumes the bench asks for one well spaced event at a time
`timescale 1ns/1ns
`default_nettype none
module atrc_src
  import atrc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // event request
  input  wire logic        fire,
  input  wire logic [3:0]  fire_code,
  // flags to the converter
  output logic [12:0]      trig_flag
);
  logic       pend_r;
  logic [3:0] code_r;
  // flags drop on a request, the chosen one rises next cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r    <= 1'b0;
      code_r    <= 4'h0;
      trig_flag <= 13'h0000;
    end else if (fire) begin
      pend_r    <= 1'b1;
      code_r    <= fire_code;
      trig_flag <= 13'h0000;
    end else if (pend_r) begin
      pend_r    <= 1'b0;
      // reserved codes raise every flag
      trig_flag <= (code_r > TRG_LAST) ? 13'h1fff :
                   13'h0001 << (code_r - 4'h1);
    end else begin
      // power-stage events have no flag, only a one-cycle pulse
      trig_flag[8:6] <= 3'b000;
    end
  end
endmodule
`default_nettype wire
